/* hdl/cae_pkg.sv */
package cae_pkg;

  // ****************************************
  // Widths and constants
  // ****************************************
  localparam int unsigned ADDR_W        = 20;
  localparam int unsigned IDX_W         = 16;
  localparam logic [19:0] FULL_LEN      = 20'h00004;
  localparam logic [19:0] SHORT_LEN     = 20'h00002;
  localparam logic [19:0] PUSH_DEC      = 20'h00004;
  localparam logic [19:0] CALL_PC_ADJ   = 20'h00002;
  localparam logic [19:0] SP_RESET      = 20'h00000;
  localparam logic [19:0] PC_RESET      = 20'h00000;

  // ****************************************
  // Operations and addressing modes
  // ****************************************
  typedef enum logic [2:0]
  {
    CAE_OP_NONE,
    CAE_OP_ADDRESS_WORD_ADD,
    CAE_OP_ADDRESS_WORD_SUBTRACT,
    CAE_OP_ADDRESS_WORD_COMPARE,
    CAE_OP_MOVE,
    CAE_OP_EXTENDED_ADDRESS_PUSH,
    CAE_OP_STACK_PUSH,
    CAE_OP_ADDRESS_CALL
  } cae_op_t;

  typedef enum logic [2:0]
  {
    CAE_AM_REGISTER,
    CAE_AM_IMMEDIATE,
    CAE_AM_ABSOLUTE,
    CAE_AM_SYMBOLIC,
    CAE_AM_INDEXED,
    CAE_AM_INDIRECT,
    CAE_AM_INDIRECT_INC
  } cae_mode_t;

  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed
  {
    cae_op_t     op;
    cae_mode_t   mode;
    logic [3:0]  reg_sel;
    logic [19:0] operand;
    logic [19:0] mem_data;
  } cae_instr_t;

  typedef struct packed
  {
    logic [19:0] pc;
    logic [19:0] sp;
    logic        stack_we;
    logic [19:0] stack_addr;
    logic [19:0] stack_data;
    logic        flag_z;
    logic        flag_n;
  } cae_result_t;

endpackage : cae_pkg

/* hdl/cae_idx_ext.sv */
`timescale 1ns/1ps
`default_nettype none

module cae_idx_ext
#(
  parameter int unsigned IW = 16,
  parameter int unsigned OW = 20
)
(
  // Index in
  input  wire logic [IW-1:0] idx_i,
  input  wire logic          sign_en_i,
  // Extended index
  output logic      [OW-1:0] ext_o
);

  // Elaboration check: the index must be narrower than the result
  if (IW >= OW)
  begin : g_bad_width
    $error("cae_idx_ext: IW must be below OW");
  end

  assign ext_o = sign_en_i ? {{(OW-IW){idx_i[IW-1]}}, idx_i} : {{(OW-IW){1'b0}}, idx_i};

endmodule : cae_idx_ext

`default_nettype wire

/* hdl/cae_core.sv */
`timescale 1ns/1ps
`default_nettype none

module cae_core
  import cae_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Instruction in
  input  wire logic             valid_i,
  input  wire cae_pkg::cae_instr_t instr_i,
  // Result out
  output logic                  done_o,
  output cae_pkg::cae_result_t  res_o
);
  import cae_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ****************************************
  // Architectural state
  // ****************************************
  logic [19:0] pc_q;
  logic [19:0] sp_q;
  logic        prev_push_mem_q;

  // Current instruction uses a memory mode (neither register nor immediate)
  logic push_mem_mode;
  assign push_mem_mode = (instr_i.mode != CAE_AM_REGISTER) && (instr_i.mode != CAE_AM_IMMEDIATE);

  logic is_push;
  assign is_push = (instr_i.op == CAE_OP_STACK_PUSH) || (instr_i.op == CAE_OP_EXTENDED_ADDRESS_PUSH);

  // Index extension unit
  logic        sign_ext_en;
  logic [19:0] idx_ext;

  assign sign_ext_en = !((instr_i.reg_sel == REG_SP) && prev_push_mem_q);

  cae_idx_ext
  #(
    .IW (IDX_W),
    .OW (ADDR_W)
  )
  u_idx
  (
    .idx_i     (instr_i.operand[15:0]),
    .sign_en_i (sign_ext_en),
    .ext_o     (idx_ext)
  );

  // ****************************************
  // Execute
  // ****************************************
  cae_result_t res_d;
  logic [19:0] pc_base;
  logic [19:0] cmp_diff;

  always_comb
  begin
    res_d            = res_o;
    res_d.pc         = pc_q + FULL_LEN;
    res_d.sp         = sp_q;
    res_d.stack_we   = 1'b0;
    res_d.stack_addr = 20'h00000;
    res_d.stack_data = 20'h00000;
    pc_base          = pc_q + FULL_LEN;
    cmp_diff         = 20'h00000;
    // Immediate with PC destination sees only half the opcode
    if ((instr_i.mode == CAE_AM_IMMEDIATE) && (instr_i.reg_sel == REG_PC))
      pc_base = pc_q + SHORT_LEN;
    case (instr_i.op)
      CAE_OP_ADDRESS_WORD_ADD:
      begin
        if (instr_i.reg_sel == REG_PC)
          res_d.pc = pc_base + instr_i.operand;
      end
      CAE_OP_ADDRESS_WORD_SUBTRACT:
      begin
        if (instr_i.reg_sel == REG_PC)
          res_d.pc = pc_base - instr_i.operand;
      end
      CAE_OP_ADDRESS_WORD_COMPARE:
      begin
        cmp_diff     = ((instr_i.reg_sel == REG_PC) ? pc_base : sp_q) - instr_i.operand;
        res_d.flag_z = (cmp_diff == 20'h00000);
        res_d.flag_n = cmp_diff[19];
      end
      CAE_OP_MOVE:
      begin
        if (instr_i.reg_sel == REG_PC)
          res_d.pc = instr_i.operand;
      end
      CAE_OP_EXTENDED_ADDRESS_PUSH,
      CAE_OP_STACK_PUSH:
      begin
        res_d.stack_we   = 1'b1;
        res_d.stack_addr = sp_q - PUSH_DEC;
        res_d.stack_data = instr_i.mem_data;
        if ((instr_i.op == CAE_OP_EXTENDED_ADDRESS_PUSH)
            && (instr_i.mode == CAE_AM_INDIRECT_INC) && (instr_i.reg_sel == REG_SP))
          res_d.sp = instr_i.mem_data;
        else
          res_d.sp = sp_q - PUSH_DEC;
      end
      CAE_OP_ADDRESS_CALL:
      begin
        res_d.stack_we   = 1'b1;
        res_d.sp         = sp_q - PUSH_DEC;
        res_d.stack_addr = sp_q - PUSH_DEC;
        res_d.stack_data = pc_q + FULL_LEN;
        if ((instr_i.mode == CAE_AM_REGISTER) && (instr_i.reg_sel == REG_PC))
        begin
          res_d.stack_data = pc_q + FULL_LEN - CALL_PC_ADJ;
          res_d.pc         = pc_q;
        end
        else if (instr_i.mode == CAE_AM_INDEXED)
          res_d.pc = ((instr_i.reg_sel == REG_SP) ? sp_q : instr_i.mem_data) + idx_ext;
        else
          res_d.pc = instr_i.mem_data;
      end
      default:
      begin
        res_d.pc = pc_q;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pc_q <= PC_RESET;
      sp_q <= SP_RESET;
    end
    else if (valid_i)
    begin
      pc_q <= res_d.pc;
      sp_q <= res_d.sp;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      prev_push_mem_q <= 1'b0;
    else if (valid_i)
      prev_push_mem_q <= is_push && push_mem_mode;
  end

  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      res_o  <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= valid_i;
      if (valid_i)
        res_o <= res_d;
      else
        res_o.stack_we <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_q);

  sequence s_push_mem;
    valid_i && is_push && push_mem_mode;
  endsequence

  sequence s_call_sp_idx;
    valid_i && instr_i.op == CAE_OP_ADDRESS_CALL && instr_i.mode == CAE_AM_INDEXED
      && instr_i.reg_sel == REG_SP;
  endsequence

  a_add_pc_short: assert property (
    (valid_i && instr_i.op == CAE_OP_ADDRESS_WORD_ADD && instr_i.mode == CAE_AM_IMMEDIATE
      && instr_i.reg_sel == REG_PC) |=> (res_o.pc == $past(pc_q) + 20'h00002 + $past(instr_i.operand)))
    else $error("immediate add to PC not offset by two");

  a_move_pc_full: assert property (
    (valid_i && instr_i.op == CAE_OP_MOVE && instr_i.reg_sel == REG_PC)
      |=> (pc_q == $past(instr_i.operand)))
    else $error("move to PC wrong");

  a_push_sp_load: assert property (
    (valid_i && instr_i.op == CAE_OP_EXTENDED_ADDRESS_PUSH && instr_i.mode == CAE_AM_INDIRECT_INC
      && instr_i.reg_sel == REG_SP) |=> (sp_q == $past(instr_i.mem_data)))
    else $error("push via SP did not load SP");

  a_call_pc_ret: assert property (
    (valid_i && instr_i.op == CAE_OP_ADDRESS_CALL && instr_i.mode == CAE_AM_REGISTER
      && instr_i.reg_sel == REG_PC) |=> (res_o.stack_data == $past(pc_q) + 20'h00002 && res_o.stack_we))
    else $error("call through PC return address wrong");

  a_call_idx_zero: assert property (
    s_push_mem ##1 s_call_sp_idx |=> (res_o.pc == $past(sp_q) + {4'h0, $past(instr_i.operand[15:0])}))
    else $error("index was sign extended after push");

  a_call_idx_sign: assert property (
    (valid_i && is_push && !push_mem_mode) ##1 s_call_sp_idx
      |=> (res_o.pc == $past(sp_q) + {{4{$past(instr_i.operand[15])}}, $past(instr_i.operand[15:0])}))
    else $error("index not sign extended after register push");

  a_sub_full_len: assert property (
    (valid_i && instr_i.op == CAE_OP_ADDRESS_WORD_SUBTRACT && instr_i.mode != CAE_AM_IMMEDIATE
      && instr_i.reg_sel == REG_PC) |=> (pc_q == $past(pc_q) + 20'h00004 - $past(instr_i.operand)))
    else $error("subtract from PC used short length");

  a_done_follow: assert property (
    valid_i |=> done_o)
    else $error("done did not follow request");

endmodule : cae_core

`default_nettype wire

/* test/cae_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cae_mem_model
  import cae_pkg::*;
(
  // Clock and stack writes
  input  wire logic                 clk_i,
  input  wire cae_pkg::cae_result_t res_i,
  // Read port
  input  wire logic [19:0]          rd_addr_i,
  output logic      [19:0]          rd_data_o
);
  logic [19:0]  mem_q [256];
  logic [255:0] vld_q = '0;

  always @(posedge clk_i)
  begin
    if (res_i.stack_we)
    begin
      mem_q[res_i.stack_addr[9:2]] <= res_i.stack_data;
      vld_q[res_i.stack_addr[9:2]] <= 1'b1;
    end
  end

  // Unwritten words read back as a pattern, not stale data
  assign rd_data_o = vld_q[rd_addr_i[9:2]] ? mem_q[rd_addr_i[9:2]] : ~rd_addr_i;
endmodule : cae_mem_model

`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench;
  import cae_pkg::*;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        valid_i = 1'b0;
  cae_instr_t  instr_i = '0;
  logic        done_o;
  cae_result_t res_o;
  logic [19:0] rd_addr = '0;
  logic [19:0] rd_data;
  logic [19:0] pc_m = '0;
  logic [19:0] sp_m = '0;
  int          fail_count = 0;
  int          samples_checked = 0;

  cae_core cae_core_inst (.clk_i(clk_i), .nrst_i(nrst_i), .valid_i(valid_i),
    .instr_i(instr_i), .done_o(done_o), .res_o(res_o));
  cae_mem_model cae_mem_model_inst (.clk_i(clk_i), .res_i(res_o),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data));

  initial forever #50 clk_i = ~clk_i;

  // ****
  // Tasks
  // ****
  task automatic run_op(input cae_op_t op, input cae_mode_t md, input logic [3:0] rs,
                        input logic [19:0] opd, input logic [19:0] mdat);
    int n = 0;
    @(posedge clk_i);
    valid_i <= 1'b1;
    instr_i <= '{op, md, rs, opd, mdat};
    @(posedge clk_i);
    valid_i <= 1'b0;
    #1;
    while (done_o !== 1'b1 && n < 4)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK(done_o, 1'b1)
  endtask : run_op

  // Two instructions on consecutive clock edges, second one judged
  task automatic run_pair(input cae_instr_t first, input cae_instr_t second);
    @(posedge clk_i);
    valid_i <= 1'b1;
    instr_i <= first;
    @(posedge clk_i);
    instr_i <= second;
    @(posedge clk_i);
    valid_i <= 1'b0;
    #1;
    `CHK(done_o, 1'b1)
  endtask : run_pair

  task automatic t_pc_arith();
    run_op(CAE_OP_ADDRESS_WORD_ADD, CAE_AM_IMMEDIATE, REG_PC, 20'h00010, 20'h0);
    pc_m = pc_m + 20'h00002 + 20'h00010;
    `CHK(res_o.pc, pc_m)
    run_op(CAE_OP_ADDRESS_WORD_SUBTRACT, CAE_AM_IMMEDIATE, REG_PC, 20'h00004, 20'h0);
    pc_m = pc_m + 20'h00002 - 20'h00004;
    `CHK(res_o.pc, pc_m)
    run_op(CAE_OP_ADDRESS_WORD_COMPARE, CAE_AM_IMMEDIATE, REG_PC, pc_m + 20'h00002, 20'h0);
    `CHK(res_o.flag_z, 1'b1)
    `CHK(res_o.flag_n, 1'b0)
    pc_m = pc_m + 20'h00004;
    `CHK(res_o.pc, pc_m)
    run_op(CAE_OP_ADDRESS_WORD_COMPARE, CAE_AM_IMMEDIATE, REG_PC, pc_m + 20'h00003, 20'h0);
    `CHK(res_o.flag_z, 1'b0)
    `CHK(res_o.flag_n, 1'b1)
    pc_m = pc_m + 20'h00004;
    run_op(CAE_OP_MOVE, CAE_AM_IMMEDIATE, REG_PC, 20'h00020, 20'h0);
    pc_m = 20'h00020;
    `CHK(res_o.pc, pc_m)
    run_op(CAE_OP_ADDRESS_WORD_SUBTRACT, CAE_AM_REGISTER, REG_PC, 20'h00008, 20'h0);
    pc_m = pc_m + 20'h00004 - 20'h00008;
    `CHK(res_o.pc, pc_m)
    $display("t_pc_arith finished");
  endtask : t_pc_arith

  task automatic t_push_sp();
    run_op(CAE_OP_STACK_PUSH, CAE_AM_REGISTER, 4'h4, 20'h00ABC, 20'h0);
    sp_m = sp_m - 20'h00004;
    `CHK(res_o.stack_addr, sp_m)
    `CHK(res_o.sp, sp_m)
    run_op(CAE_OP_EXTENDED_ADDRESS_PUSH, CAE_AM_INDIRECT_INC, 4'h4, 20'h0, 20'h00777);
    sp_m = sp_m - 20'h00004;
    `CHK(res_o.sp, sp_m)
    run_op(CAE_OP_EXTENDED_ADDRESS_PUSH, CAE_AM_INDIRECT_INC, REG_SP, 20'h0, 20'h01230);
    sp_m = 20'h01230;
    `CHK(res_o.sp, sp_m)
    $display("t_push_sp finished");
  endtask : t_push_sp

  task automatic t_call_idx();
    cae_mode_t   md;
    cae_op_t     pop;
    logic [19:0] tgt;
    for (int m = 0; m < 7; m++)
    begin
      md = cae_mode_t'(m);
      if (m[0])
        pop = CAE_OP_STACK_PUSH;
      else
        pop = CAE_OP_EXTENDED_ADDRESS_PUSH;
      sp_m = sp_m - 20'h00004;
      tgt = sp_m + ((md == CAE_AM_REGISTER || md == CAE_AM_IMMEDIATE) ? 20'hFFFF0 : 20'h0FFF0);
      run_pair(cae_instr_t'{pop, md, 4'h4, 20'h0, 20'h0},
               cae_instr_t'{CAE_OP_ADDRESS_CALL, CAE_AM_INDEXED, REG_SP, 20'h0FFF0, 20'h0});
      sp_m = sp_m - 20'h00004;
      `CHK(res_o.pc, tgt)
      `CHK(res_o.sp, sp_m)
    end
    // An idle cycle between push and call does not hide the anomaly
    run_op(CAE_OP_STACK_PUSH, CAE_AM_INDIRECT, 4'h4, 20'h0, 20'h0);
    sp_m = sp_m - 20'h00004;
    tgt = sp_m + 20'h0FFF0;
    run_op(CAE_OP_ADDRESS_CALL, CAE_AM_INDEXED, REG_SP, 20'h0FFF0, 20'h0);
    sp_m = sp_m - 20'h00004;
    `CHK(res_o.pc, tgt)
    run_op(CAE_OP_STACK_PUSH, CAE_AM_ABSOLUTE, 4'h4, 20'h0, 20'h0);
    sp_m = sp_m - 20'h00008;
    pc_m = 20'h3FFF0;
    run_op(CAE_OP_ADDRESS_CALL, CAE_AM_INDEXED, 4'h5, 20'h0FFF0, 20'h40000);
    `CHK(res_o.pc, pc_m)
    `CHK(res_o.sp, sp_m)
    $display("t_call_idx finished");
  endtask : t_call_idx

  task automatic t_call_pc();
    run_op(CAE_OP_ADDRESS_CALL, CAE_AM_REGISTER, 4'h5, 20'h0, 20'h05000);
    sp_m = sp_m - 20'h00004;
    `CHK(res_o.stack_data, pc_m + 20'h00004)
    pc_m = 20'h05000;
    `CHK(res_o.pc, pc_m)
    run_op(CAE_OP_ADDRESS_CALL, CAE_AM_REGISTER, REG_PC, 20'h0, 20'h0);
    sp_m = sp_m - 20'h00004;
    rd_addr = sp_m;
    `CHK(res_o.stack_data, pc_m + 20'h00002)
    `CHK(res_o.stack_addr, sp_m)
    `CHK(res_o.stack_we, 1'b1)
    @(posedge clk_i);
    #1;
    `CHK(rd_data, pc_m + 20'h00002)
    `CHK(res_o.stack_we, 1'b0)
    $display("t_call_pc finished");
  endtask : t_call_pc

  task automatic results();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // ****
  // Main sequence and watchdog
  // ****
  initial
  begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(done_o, 1'b0)
    `CHK(res_o, cae_result_t'('0))
    t_pc_arith();
    t_push_sp();
    t_call_idx();
    t_call_pc();
    results();
  end

  initial
  begin
    #300000;
    fail_count++;
    results();
  end
endmodule : testbench

`default_nettype wire
